// *** core/mnes_pkg.sv ***
// Constants, register map and types for the NAND ECC sequencer.
// Assumes a 125 MHz system clock and a classic Wishbone register port.
package mnes_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD       = 8'h00;
	localparam logic [7:0] OFS_ADDR      = 8'h04;
	localparam logic [7:0] OFS_DATA      = 8'h08;
	localparam logic [7:0] OFS_BUF       = 8'h0c;
	localparam logic [7:0] OFS_START_ENC = 8'h10;
	localparam logic [7:0] OFS_START_DEC = 8'h14;
	localparam logic [7:0] OFS_WR_PAR    = 8'h18;
	localparam logic [7:0] OFS_RD_PAR    = 8'h1c;
	localparam logic [7:0] OFS_AUTO_ENC  = 8'h20;
	localparam logic [7:0] OFS_AUTO_DEC  = 8'h24;
	localparam logic [7:0] OFS_STATUS    = 8'h28;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h2c;
	localparam logic [7:0] OFS_CTRL      = 8'h30;
	// Flash commands
	localparam logic [7:0] CMD_READ_MAIN  = 8'h00;
	localparam logic [7:0] CMD_READ_SPARE = 8'h50;
	localparam logic [7:0] CMD_ERASE_SET  = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO   = 8'hd0;
	localparam logic [7:0] CMD_RESET      = 8'hff;
	// Field positions
	localparam int ST_NAND_RDY   = 0;
	localparam int ST_CTL_RDY    = 1;
	localparam int ST_ECC_RDY    = 2;
	localparam int ST_ERR        = 3;
	localparam int ST_FAIL       = 4;
	localparam int AENC_PROG_BIT = 8;
	localparam int CTRL_SWWP_BIT = 0;
	localparam int IRQ_N         = 4;
	localparam int IRQ_CTL       = 0;
	localparam int IRQ_ECC       = 1;
	localparam int IRQ_ERR       = 2;
	localparam int IRQ_FAIL      = 3;
	// Codeword layout: data bytes, then parity lanes
	localparam int         PAR_N     = 10;
	localparam logic [9:0] DATA_N    = 10'h206;
	localparam logic [9:0] CW_N      = 10'h210;
	localparam logic [9:0] SPARE_OFS = 10'h200;
	// Strobe timing
	localparam int CLK_NS  = 8;
	localparam int T_PW_NS = 40;
	localparam int T_HD_NS = 24;
	localparam int T_WB_NS = 100;
	localparam logic [3:0] PW_CYC = 4'((T_PW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] HD_CYC = 4'((T_HD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] WB_CYC = 4'((T_WB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] LAST_PH = PW_CYC + HD_CYC - 4'h1;
	typedef enum logic [1:0] {K_CMD, K_ADDR, K_WR, K_RD} mnes_kind_t;
	typedef enum logic [2:0] {S_IDLE, S_CPU, S_RDX, S_WRX, S_PROG} mnes_st_t;
	typedef struct packed {
		mnes_st_t                  st;
		mnes_kind_t                kind;
		logic                      busy;
		logic [3:0]                ph;
		logic [3:0]                hold;
		logic [7:0]                obyte;
		logic [7:0]                rbyte;
		logic [9:0]                cnt;
		logic [3:0]                lane;
		logic [9:0]                bufptr;
		logic [PAR_N-1:0][7:0]     par;
		logic [PAR_N-1:0][7:0]     rpar;
		logic                      ack;
		logic [DAT_W-1:0]          rdat;
		logic                      swwp;
		logic [IRQ_N-1:0]          irq_en;
		logic [IRQ_N-1:0]          evt;
		logic                      ctl_rdy;
		logic                      ecc_rdy;
		logic                      err;
		logic                      fail;
		logic                      enc_on;
		logic                      dec_on;
		logic                      prd;
		logic                      spare;
		logic [1:0]                arm;
		logic                      autoprog;
		logic [7:0]                progcmd;
		logic                      rdy_m;
		logic                      rdy_s;
		logic                      wp_m;
		logic                      wp_s;
		logic [7:0]                io_m;
		logic [7:0]                io_s;
	} mnes_state_t;
endpackage

// *** core/mnes_sequencer.sv ***
// NAND flash operation sequencer with codeword check, Wishbone slave.
// Assumes one 125 MHz clock; flash pins are asynchronous and synchronised.
`timescale 1ns/100ps
// Contract
// (R1) Spare read command 0x50 goes to flash as main read 0x00.
// (R2) Auto decode: 0x00, address, trigger, poll ready, read 518/528 from buffer.
// (R3) Spare read: auto decode, poll ready, fetch 6/16 overhead bytes.
// (R4) Large block: software sends 0x30 after 0x00 before address.
// (R5) Large block: four decode or encode cycles, one per quarter page.
// (R6) Normal decode: read 518 bytes, parity read trigger, wait ECC ready.
// (R7) Reading 528 bytes directly replaces the parity read trigger.
// (R8) Decode end raises error or failure event when enabled.
// (R9) Auto decode or encode end raises controller ready event when enabled.
// (R10) Parity read end raises ECC ready event when enabled.
// (R11) Normal encode: 0x80, address, trigger, 518 bytes, write parity, poll.
// (R12) Auto encode without program: bit 8 clear, software sends program.
// (R13) Auto encode with bit 8 set sends program command after parity.
// (R14) Large block auto program: only the last quarter sets bit 8.
// (R15) Erase: 0x60, block address, then 0xD0.
// (R16) Erase confirm without setup and address becomes reset 0xFF.
// (R17) Write protection withholds erase confirm.
// (R18) Software checks controller not busy before other flash operations.
// (R19) Controller ready clears at parity or auto cycle start, sets at end.
// (R20) ECC ready shows encode or decode has finished.
module mnes_sequencer (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [mnes_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [mnes_pkg::DAT_W-1:0]  wb_dat_i,
	input  wire logic [3:0]                  wb_sel_i,
	output logic      [mnes_pkg::DAT_W-1:0]  wb_dat_o,
	output logic                             wb_ack_o,
	output logic      [mnes_pkg::IRQ_N-1:0]  irq_evt_o,
	input  wire logic                        flash_ready_i,
	input  wire logic                        flash_wp_n_i,
	input  wire logic [7:0]                  flash_io_i,
	output logic      [7:0]                  flash_io_o,
	output logic                             flash_io_oe_o,
	output logic                             flash_cle_o,
	output logic                             flash_ale_o,
	output logic                             flash_we_n_o,
	output logic                             flash_re_n_o,
	output logic                             flash_ce_n_o
);
	import mnes_pkg::*;

	mnes_state_t      s;
	mnes_state_t      n;
	logic [7:0]       buf_mem [0:CW_N-1];
	logic             bw_en;
	logic [9:0]       bw_addr;
	logic [7:0]       bw_data;
	logic             req;
	logic [DAT_W-1:0] wd;
	logic             go;
	mnes_kind_t       go_kind;
	logic [7:0]       go_byte;
	logic             ab_en;
	logic             ab_rd;
	logic [7:0]       ab_b;
	logic             done;
	logic             nand_rdy;

	assign done     = s.busy && (s.ph == LAST_PH);
	// Ready stays low until the busy window after a write has passed
	assign nand_rdy = s.rdy_s && (s.hold == 4'h0) && !s.busy;
	assign wd       = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign req      = wb_cyc_i && wb_stb_i && !s.ack;

	always_comb begin
		int nm;
		nm = 0;
		n = s;
		n.ack = 1'b0;
		n.evt = '0;
		n.rdy_m = flash_ready_i;
		n.rdy_s = s.rdy_m;
		n.wp_m = flash_wp_n_i;
		n.wp_s = s.wp_m;
		n.io_m = flash_io_i;
		n.io_s = s.io_m;
		go = 1'b0;
		go_kind = K_CMD;
		go_byte = 8'h00;
		ab_en = 1'b0;
		ab_rd = 1'b0;
		ab_b = s.obyte;
		bw_en = 1'b0;
		bw_addr = s.cnt;
		bw_data = s.rbyte;
		// Byte strobe engine
		if (s.busy) begin
			n.ph = s.ph + 4'h1;
			if (s.kind == K_RD && s.ph == PW_CYC - 4'h1)
				n.rbyte = s.io_s;
			if (done) begin
				n.busy = 1'b0;
				if (s.kind != K_RD)
					n.hold = WB_CYC;
			end
		end else if (s.hold != 4'h0) begin
			n.hold = s.hold - 4'h1;
		end
		// Status, interrupt enable and control registers answer in any state
		if (req && (wb_adr_i == OFS_STATUS || wb_adr_i == OFS_IRQ_EN ||
				wb_adr_i == OFS_CTRL)) begin
			n.ack = 1'b1;
			n.rdat = '0;
			case (wb_adr_i)
				OFS_STATUS: begin
					n.rdat[ST_NAND_RDY] = nand_rdy;
					n.rdat[ST_CTL_RDY] = s.ctl_rdy;    // R19
					n.rdat[ST_ECC_RDY] = s.ecc_rdy;    // R20
					n.rdat[ST_ERR] = s.err;
					n.rdat[ST_FAIL] = s.fail;
				end
				OFS_IRQ_EN: begin
					if (wb_we_i)
						n.irq_en = wd[IRQ_N-1:0];
					n.rdat[IRQ_N-1:0] = s.irq_en;
				end
				default: begin
					if (wb_we_i)
						n.swwp = wd[CTRL_SWWP_BIT];
					n.rdat[CTRL_SWWP_BIT] = s.swwp;
				end
			endcase
		end else if (req && s.st == S_IDLE) begin
			// Flash-facing accesses wait here while a cycle runs
			n.rdat = '0;
			n.ack = 1'b1;
			case (wb_adr_i)
				OFS_CMD: if (wb_we_i) begin
					n.ack = 1'b0;
					go = 1'b1;
					go_byte = wd[7:0];
					n.spare = (wd[7:0] == CMD_READ_SPARE);
					n.arm = (wd[7:0] == CMD_ERASE_SET) ? 2'h1 : 2'h0;
					if (wd[7:0] == CMD_READ_SPARE)
						go_byte = CMD_READ_MAIN;    // R1
					if (wd[7:0] == CMD_ERASE_GO) begin
						if (s.swwp || !s.wp_s) begin
							go = 1'b0;    // R17
							n.ack = 1'b1;
						end else if (s.arm != 2'h2) begin
							go_byte = CMD_RESET;    // R16
						end
					end
				end
				OFS_ADDR: if (wb_we_i) begin
					n.ack = 1'b0;
					go = 1'b1;
					go_kind = K_ADDR;
					go_byte = wd[7:0];
					if (s.arm != 2'h0)
						n.arm = 2'h2;    // R15
				end
				OFS_DATA: begin
					n.ack = 1'b0;
					go = 1'b1;
					go_kind = wb_we_i ? K_WR : K_RD;
					go_byte = wd[7:0];
				end
				OFS_BUF: begin
					n.bufptr = (s.bufptr == CW_N - 10'h1) ? 10'h0 : s.bufptr + 10'h1;
					n.rdat[7:0] = buf_mem[s.bufptr];
					if (wb_we_i) begin
						bw_en = 1'b1;
						bw_addr = s.bufptr;
						bw_data = wd[7:0];
					end
				end
				OFS_START_ENC, OFS_START_DEC, OFS_AUTO_ENC, OFS_AUTO_DEC: if (wb_we_i) begin
					n.cnt = 10'h0;
					n.lane = 4'h0;
					n.par = '0;
					n.ecc_rdy = 1'b0;
					n.bufptr = 10'h0;
					if (wb_adr_i == OFS_START_ENC || wb_adr_i == OFS_AUTO_ENC) begin
						n.enc_on = 1'b1;
						n.dec_on = 1'b0;
					end else begin
						n.dec_on = 1'b1;
						n.enc_on = 1'b0;
						n.err = 1'b0;
						n.fail = 1'b0;
						n.prd = 1'b0;
					end
					if (wb_adr_i == OFS_AUTO_ENC) begin
						n.st = S_WRX;
						n.ctl_rdy = 1'b0;    // R19
						n.autoprog = wd[AENC_PROG_BIT];    // R13
						n.progcmd = wd[7:0];
					end
					if (wb_adr_i == OFS_AUTO_DEC) begin
						n.st = S_RDX;
						n.ctl_rdy = 1'b0;    // R19
						n.bufptr = s.spare ? SPARE_OFS : 10'h0;    // R3
					end
				end
				OFS_WR_PAR: if (wb_we_i && s.enc_on) begin
					n.st = S_WRX;
					n.cnt = DATA_N;
					n.autoprog = 1'b0;
					n.ctl_rdy = 1'b0;    // R19
				end
				OFS_RD_PAR: if (wb_we_i && s.dec_on) begin
					n.st = S_RDX;
					n.prd = 1'b1;
					n.ctl_rdy = 1'b0;    // R19
				end
				default: ;
			endcase
			if (go)
				n.st = S_CPU;
		end
		// Cycle sequencing
		case (s.st)
			S_CPU: if (done) begin
				n.st = S_IDLE;
				n.ack = 1'b1;
				n.rdat = {24'h0, (s.kind == K_RD) ? s.rbyte : 8'h00};
				ab_en = (s.kind == K_WR && s.enc_on && s.cnt < DATA_N) ||
					(s.kind == K_RD && s.dec_on && s.cnt < CW_N);    // R7
				ab_rd = (s.kind == K_RD);
			end
			S_RDX: begin
				if (!s.busy) begin
					go = 1'b1;
					go_kind = K_RD;
				end
				ab_en = done;
				ab_rd = 1'b1;
			end
			S_WRX: begin
				if (!s.busy) begin
					go = 1'b1;
					go_kind = K_WR;
					go_byte = (s.cnt < DATA_N) ? buf_mem[s.cnt] : s.par[4'(s.cnt - DATA_N)];
				end
				ab_en = done;
				if (done && s.cnt == CW_N - 10'h1)
					n.st = S_PROG;
			end
			S_PROG: begin
				if (!s.busy && s.autoprog) begin
					go = 1'b1;
					go_byte = s.progcmd;    // R13
					n.autoprog = 1'b0;
				end
				if ((!s.busy && !s.autoprog) || done) begin
					n.st = S_IDLE;
					n.ctl_rdy = 1'b1;    // R19
					n.ecc_rdy = 1'b1;    // R20
					n.enc_on = 1'b0;
					n.evt[IRQ_CTL] = s.irq_en[IRQ_CTL];    // R9
				end
			end
			default: ;
		endcase
		if (go) begin
			n.busy = 1'b1;
			n.ph = 4'h0;
			n.kind = go_kind;
			n.obyte = go_byte;
		end
		// Codeword absorb: data bytes fold into parity lanes
		if (ab_en) begin
			if (ab_rd) begin
				ab_b = s.rbyte;
				bw_en = 1'b1;
			end
			if (s.cnt < DATA_N) begin
				n.par[s.lane] = s.par[s.lane] ^ ab_b;
				n.lane = (s.lane == 4'(PAR_N - 1)) ? 4'h0 : s.lane + 4'h1;
			end else if (ab_rd) begin
				n.rpar[4'(s.cnt - DATA_N)] = ab_b;
			end
			n.cnt = s.cnt + 10'h1;
			if (ab_rd && s.cnt == CW_N - 10'h1) begin
				for (int i = 0; i < PAR_N; i++)
					if (n.par[i] != n.rpar[i])
						nm = nm + 1;
				n.dec_on = 1'b0;
				n.ecc_rdy = 1'b1;    // R20
				n.err = (nm != 0);
				// Simple lane parity detects but cannot locate errors
				n.fail = (nm > 1);
				n.evt[IRQ_ERR] = (nm != 0) && s.irq_en[IRQ_ERR];    // R8
				n.evt[IRQ_FAIL] = (nm > 1) && s.irq_en[IRQ_FAIL];    // R8
				if (s.st == S_RDX) begin
					n.st = S_IDLE;
					n.ctl_rdy = 1'b1;    // R19
					n.evt[IRQ_CTL] = !s.prd && s.irq_en[IRQ_CTL];    // R9
				end
				n.evt[IRQ_ECC] = (s.st != S_RDX || s.prd) && s.irq_en[IRQ_ECC];    // R10
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s <= '0;
		else
			s <= n;
	end

	// Buffer has its own port; bus and engine writes never meet (idle gate)
	always_ff @(posedge clk_i) begin
		if (bw_en)
			buf_mem[bw_addr] <= bw_data;
	end

	assign wb_dat_o      = s.rdat;
	assign wb_ack_o      = s.ack;
	assign irq_evt_o     = s.evt;
	assign flash_io_o    = s.obyte;
	assign flash_io_oe_o = s.busy && (s.kind != K_RD);
	assign flash_cle_o   = s.busy && (s.kind == K_CMD);
	assign flash_ale_o   = s.busy && (s.kind == K_ADDR);
	assign flash_we_n_o  = !(s.busy && s.kind != K_RD && s.ph < PW_CYC);
	assign flash_re_n_o  = !(s.busy && s.kind == K_RD && s.ph < PW_CYC);
	assign flash_ce_n_o  = !(s.busy || s.st != S_IDLE);
endmodule // mnes_sequencer

// *** tb/mnes_sequencer_monitor.sv ***
// Bound checker for the sequencer's bus and flash pins.
// Assumes bind into mnes_sequencer; one clock, synchronous reset.
`timescale 1ns/100ps
module mnes_sequencer_monitor
	import mnes_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       flash_wp_n_i,
	input wire logic [7:0] flash_io_o,
	input wire logic       flash_io_oe_o,
	input wire logic       flash_cle_o,
	input wire logic       flash_we_n_o,
	input wire logic       flash_re_n_o,
	input wire logic       flash_ce_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack over one cycle");
	property p_ack_req; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_we_len; $fell(flash_we_n_o) |-> (!flash_we_n_o)[*5] ##1 flash_we_n_o; endproperty
	a_we_len: assert property (p_we_len) else $error("write strobe width");
	property p_re_len; $fell(flash_re_n_o) |-> (!flash_re_n_o)[*5] ##1 flash_re_n_o; endproperty
	a_re_len: assert property (p_re_len) else $error("read strobe width");
	property p_drive; !flash_we_n_o |-> flash_io_oe_o && flash_re_n_o && !flash_ce_n_o; endproperty
	a_drive: assert property (p_drive) else $error("write byte not driven");
	property p_release; !flash_re_n_o |-> !flash_io_oe_o && !flash_ce_n_o; endproperty
	a_release: assert property (p_release) else $error("bus driven during read");
	// Byte and latch must not move while the part may still latch them
	property p_hold; $fell(flash_we_n_o) |=> ($stable(flash_io_o) && $stable(flash_cle_o))[*5];
	endproperty
	a_hold: assert property (p_hold) else $error("byte changed under strobe");
	property p_spare; flash_cle_o && !flash_we_n_o |-> flash_io_o != CMD_READ_SPARE; endproperty
	a_spare: assert property (p_spare) else $error("spare read sent to flash");
	property p_wp; flash_cle_o && !flash_we_n_o && flash_io_o == CMD_ERASE_GO |-> flash_wp_n_i;
	endproperty
	a_wp: assert property (p_wp) else $error("erase confirm under protect");
endmodule // mnes_sequencer_monitor
bind mnes_sequencer mnes_sequencer_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .flash_wp_n_i, .flash_io_o, .flash_io_oe_o, .flash_cle_o, .flash_we_n_o,
	.flash_re_n_o, .flash_ce_n_o);

// *** tb/mnes_flash_model.sv ***
// NAND part model: latches commands, serves a fixed page image.
// Assumes strobes are slow against clk_i; edges are found by sampling.
`timescale 1ns/100ps
module mnes_flash_model (
	input  wire logic       clk_i,
	input  wire logic [1:0] bad_i,
	input  wire logic [7:0] io_i,
	input  wire logic       cle_i,
	input  wire logic       ale_i,
	input  wire logic       we_n_i,
	input  wire logic       re_n_i,
	input  wire logic       ce_n_i,
	output logic      [7:0] io_o,
	output logic            ready_o,
	output logic      [7:0] cmd_o,
	output logic      [7:0] ncmd_o,
	output logic      [7:0] par_o
);
	logic [9:0] idx;
	logic [7:0] busy, last, rdb;
	logic       we_q, re_q;
	// 518 bytes of 0x5a, the first bad_i of them 0x5b; lanes 8 and 9 carry 0x5a
	assign rdb = (idx < 10'h206) ? {7'h2d, idx < {8'h00, bad_i}} :
		(idx >= 10'h20e ? 8'h5a : 8'h00);
	// Released bus shows the inverse, never a stale good byte
	assign io_o = (!re_n_i && !ce_n_i) ? rdb : ~last;
	assign ready_o = busy == 8'h00;
	initial begin
		idx = '0;
		busy = '0;
		last = '0;
		we_q = 1'b1;
		re_q = 1'b1;
		cmd_o = '0;
		ncmd_o = '0;
		par_o = '0;
	end
	always @(posedge clk_i) begin
		we_q <= we_n_i;
		re_q <= re_n_i;
		if (busy != 8'h00) busy <= busy - 8'h01;
		if (we_n_i && !we_q && !ce_n_i) begin
			if (cle_i) begin
				cmd_o <= io_i;
				ncmd_o <= ncmd_o + 8'h01;
				idx <= '0;
				busy <= 8'h14;
			end else if (!ale_i) begin
				if (idx == 10'h20e) par_o <= io_i;
				idx <= idx + 10'h001;
			end
		end
		if (re_n_i && !re_q && !ce_n_i) begin
			last <= rdb;
			idx <= idx + 10'h001;
		end
	end
endmodule // mnes_flash_model

// *** tb/mnes_sequencer_bench.sv ***
// Self-checking bench for the NAND ECC sequencer over Wishbone.
// Assumes mnes_flash_model on the flash pins and the bound monitor.
`timescale 1ns/100ps
module mnes_sequencer_bench;
	import mnes_pkg::*;
	logic             clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic             wb_we_i = 1'b0, flash_wp_n_i = 1'b1;
	logic [1:0]       bad = 2'h0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [DAT_W-1:0] wb_dat_i = '0, wb_dat_o, q;
	logic             wb_ack_o, flash_ready_i, flash_io_oe_o, flash_cle_o, flash_ale_o;
	logic             flash_we_n_o, flash_re_n_o, flash_ce_n_o;
	logic [IRQ_N-1:0] irq_evt_o;
	logic [7:0]       flash_io_i, flash_io_o, cmd, ncmd, par, n;
	logic [31:0]      evc [IRQ_N];
	int               num_errors = 0, n_checks = 0, cycles = 0;
	always #4 clk_i = ~clk_i;
	mnes_sequencer u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
		.wb_sel_i(4'hf), .wb_dat_o, .wb_ack_o, .irq_evt_o, .flash_ready_i, .flash_wp_n_i,
		.flash_io_i, .flash_io_o, .flash_io_oe_o, .flash_cle_o, .flash_ale_o, .flash_we_n_o,
		.flash_re_n_o, .flash_ce_n_o);
	mnes_flash_model u_nand (.clk_i, .bad_i(bad), .io_i(flash_io_o), .cle_i(flash_cle_o),
		.ale_i(flash_ale_o), .we_n_i(flash_we_n_o), .re_n_i(flash_re_n_o), .ce_n_i(flash_ce_n_o),
		.io_o(flash_io_i), .ready_o(flash_ready_i), .cmd_o(cmd), .ncmd_o(ncmd), .par_o(par));
	// Event pulses last one cycle, so count them as they pass
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		for (int i = 0; i < IRQ_N; i++) begin
			if (rst_i)
				evc[i] <= 32'h0;
			else if (irq_evt_o[i] === 1'b1)
				evc[i] <= evc[i] + 32'h1;
		end
		if (cycles == 80000) begin
			num_errors = num_errors + 1;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, '0);
	endtask
	// Status polls cost one bus cycle each; bounded by count and timeout
	task automatic poll(input int b);
		for (int i = 0; i < 4000; i++) begin
			rd(OFS_STATUS);
			if (q[b] === 1'b1) break;
		end
		chk(32'(q[b]), 1);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_STATUS);
		chk(q & 32'h1e, 0);
		rd(8'hfc);
		chk(q, 0);
		wr(OFS_IRQ_EN, 32'hf);
		wr(OFS_CMD, 32'hd0);
		chk({24'h0, cmd}, 32'hff);
		wr(OFS_CMD, 32'h60);
		wr(OFS_ADDR, 32'h12);
		wr(OFS_CMD, 32'hd0);
		chk({24'h0, cmd}, 32'hd0);
		for (int k = 0; k < 2; k++) begin
			wr(OFS_CTRL, 32'(k == 0));
			flash_wp_n_i <= (k == 0);
			repeat (4) @(posedge clk_i);
			n = ncmd;
			wr(OFS_CMD, 32'h60);
			wr(OFS_ADDR, 32'h12);
			wr(OFS_CMD, 32'hd0);
			chk({24'h0, ncmd}, {24'h0, n + 8'h01});
		end
		flash_wp_n_i <= 1'b1;
		wr(OFS_CTRL, 0);
		$display("erase test done");
		for (int k = 0; k < 3; k++) begin
			bad <= 2'(k);
			wr(OFS_CMD, k == 2 ? 32'h50 : 32'h00);
			chk({24'h0, cmd}, 32'h00);
			if (k == 0) begin
				wr(OFS_CMD, 32'h30);
				chk({24'h0, cmd}, 32'h30);
			end
			wr(OFS_ADDR, 0);
			wr(OFS_AUTO_DEC, 0);
			rd(OFS_STATUS);
			chk(32'(q[ST_CTL_RDY]), 0);
			poll(ST_CTL_RDY);
			chk(32'(q[4:3]), (k == 2) ? 3 : k);
			chk(evc[IRQ_CTL], k + 1);
			for (int i = 0; i < 7; i++) begin
				rd(OFS_BUF);
				chk(q, (k == 2 && i == 6) ? 0 : ((k == 1 && i == 0) ? 32'h5b : 32'h5a));
			end
		end
		chk(evc[IRQ_ERR], 2);
		chk(evc[IRQ_FAIL], 1);
		$display("auto decode test done");
		bad <= 2'h0;
		// Second pass reads the whole codeword and skips the parity trigger
		for (int k = 0; k < 2; k++) begin
			wr(OFS_CMD, 0);
			wr(OFS_ADDR, 0);
			poll(ST_NAND_RDY);
			wr(OFS_START_DEC, 0);
			for (int i = 0; i < (k == 0 ? 518 : 528); i++) begin
				rd(OFS_DATA);
				chk(q, (i < 518 || i > 525) ? 32'h5a : 32'h00);
			end
			if (k == 0)
				wr(OFS_RD_PAR, 0);
			poll(ST_ECC_RDY);
			chk(32'(q[4:3]), 0);
			chk(evc[IRQ_ECC], k + 1);
		end
		$display("normal decode test done");
		// Four quarter pages; only the last asks for the program command
		for (int k = 0; k < 4; k++) begin
			if (k == 0) begin
				wr(OFS_CMD, 32'h80);
				wr(OFS_ADDR, 0);
			end
			wr(OFS_START_ENC, 0);
			repeat (518) wr(OFS_BUF, 32'h5a);
			wr(OFS_AUTO_ENC, k == 3 ? 32'h110 : 32'h000);
			poll(ST_CTL_RDY);
			chk({24'h0, cmd}, k == 3 ? 32'h10 : 32'h80);
			chk({24'h0, par}, 32'h5a);
			chk(evc[IRQ_CTL], k + 4);
		end
		wr(OFS_CMD, 32'h80);
		wr(OFS_ADDR, 0);
		wr(OFS_START_ENC, 0);
		repeat (518) wr(OFS_DATA, 32'ha5);
		wr(OFS_WR_PAR, 0);
		poll(ST_CTL_RDY);
		chk({24'h0, par}, 32'ha5);
		chk(evc[IRQ_CTL], 8);
		wr(OFS_CMD, 32'h10);
		chk({24'h0, cmd}, 32'h10);
		chk(evc[IRQ_FAIL], 1);
		$display("encode test done");
		test_done();
	end
endmodule // mnes_sequencer_bench
